// File: core/aoa_top.sv
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "aoa_defines.svh"

module aoa_top #(
  parameter int DIO_N = `AOA_DIO_N,     // Number of switchable digital pins.
  parameter int RELAY_N = `AOA_RELAY_N, // Number of relay outputs.
  parameter int LIST_N = `AOA_LIST_N,   // Entries in the assignable list.
  parameter int AXES = 2,               // Axes served by this unit.
  parameter int CARDS = 2               // Analog option cards fitted.
) (
  input wire logic pclk,                          // APB clock, 250 MHz.
  input wire logic presetn,                       // Asynchronous reset, active low.
  input wire logic psel,                          // APB select.
  input wire logic penable,                       // APB enable.
  input wire logic pwrite,                        // APB direction, high for write.
  input wire logic [7:0] paddr,                   // APB byte address.
  input wire logic [31:0] pwdata,                 // APB write data.
  output logic [31:0] prdata,                     // APB read data.
  output logic pready,                            // APB ready.
  output logic pslverr,                           // APB error.
  output logic [`AOA_ID_W-1:0] param_id_a,        // Identifier fetched for channel A.
  output logic [`AOA_ID_W-1:0] param_id_b,        // Identifier fetched for channel B.
  input wire logic signed [31:0] param_val_a,     // Current value of A's source.
  input wire logic param_bin_a,                   // A's source is binary.
  input wire logic signed [31:0] param_val_b,     // Current value of B's source.
  input wire logic param_bin_b,                   // B's source is binary.
  output logic signed [15:0] aout1_mv,            // Output 1 voltage in millivolts.
  output logic signed [15:0] aout2_mv,            // Output 2 voltage in millivolts.
  output logic signed [15:0] aout3_mv,            // Output 3 voltage in millivolts.
  output logic signed [15:0] aout4_mv,            // Output 4 voltage in millivolts.
  output logic signed [15:0] aout5_mv,            // Output 5 voltage in millivolts.
  output logic signed [15:0] aout6_mv,            // Output 6 voltage in millivolts.
  input wire logic [`AOA_DIO_N-1:0] dio_i,        // Digital pin levels from outside.
  output logic [`AOA_DIO_N-1:0] dio_o,            // Digital pin drive values.
  output logic [`AOA_DIO_N-1:0] dio_oe_n,         // Pin drive enables, low drives.
  output logic [`AOA_RELAY_N-1:0] relay_o         // Relay coil drives.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Build-time facts.

  // Outputs 5 and 6 only exist on a two-axis unit with two analog cards.
  localparam bit HAS_56 = (AXES == 2) && (CARDS == 2);

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Saturate a wide signed millivolt figure to the legal output range.
  function automatic logic signed [15:0] aoa_clamp(input logic signed [47:0] mv);
    logic signed [15:0] r;
    r = `AOA_MV_RESET;
    // Compare at full width so a huge figure cannot wrap into range.
    if (mv > 48'(`AOA_MV_MAX)) begin
      r = `AOA_MV_MAX;
    end else if (mv < 48'(`AOA_MV_MIN)) begin
      r = `AOA_MV_MIN;
    end else begin
      r = mv[15:0];
    end
    return r;
  endfunction

  // Convert a source value into an output voltage for one channel.
  function automatic logic signed [15:0] aoa_conv(input logic signed [31:0] val,
                                                  input logic signed [31:0] zero,
                                                  input logic signed [31:0] scale,
                                                  input logic bin);
    logic signed [47:0] num;
    logic signed [47:0] q;
    logic signed [15:0] r;
    num = 48'sd0;
    q = 48'sd0;
    r = `AOA_MV_RESET;
    if (bin) begin
      // The zero reference plays no part here; scaling names the bit.
      r = val[scale[4:0]] ? `AOA_MV_BIT_SET : `AOA_MV_RESET;
    end else begin
      // 48 bits hold a 32-bit difference times one thousand with room.
      num = (48'(val) - 48'(zero)) * `AOA_MV_PER_V;
      if (scale == 32'sd0) begin
        // A zero scaling would divide by zero, so the undivided figure goes straight to the clamp.
        q = num;
      end else begin
        q = num / 48'(scale);
      end
      // Division truncates toward zero, so small remainders are dropped.
      r = aoa_clamp(q);
    end
    return r;
  endfunction

  // True when an identifier is held in the list of assignable sources.
  function automatic logic aoa_listed(input logic [LIST_N-1:0][`AOA_ID_W-1:0] lst,
                                      input logic [`AOA_ID_W-1:0] id);
    logic hit;
    hit = 1'b0;
    // A plain scan suits a short list; a long one would want a lookup.
    for (int i = 0; i < LIST_N; i++) begin
      if (lst[i] == id) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  aoa_pkg::aoa_state_t s_q; // Registered state.
  aoa_pkg::aoa_state_t s_d; // Next state.

  // Bus helpers, all combinational.
  logic acc;   // Access phase seen, answer not yet given.
  logic done;  // Access phase completing this cycle.
  logic [31:0] wv; // Write data, named for readability.
  logic [31:0] rd; // Read data mux.
  logic hit;   // Address is mapped.
  logic [7:0] lbase; // Offset into the list window.

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // The bus inserts one wait state: data is looked up in the first access cycle
  // and presented from a flip-flop in the second, where a write also lands.
  always_comb begin
    s_d = s_q;
    wv = pwdata;
    acc = psel && penable && !s_q.pready;
    done = psel && penable && s_q.pready;
    rd = 32'h0000_0000;
    hit = 1'b1;
    lbase = paddr - `AOA_OFF_LIST;

    // Pins pass two flip-flops before anything reads them.
    s_d.din_s1 = dio_i;
    s_d.din_s2 = s_q.din_s1;

    // Read decode.
    if (paddr == `AOA_OFF_CTRL) begin
      // Only the two mode bits exist; the rest read zero.
      rd[`AOA_CTRL_MODE_A] = s_q.mode_a;
      rd[`AOA_CTRL_MODE_B] = s_q.mode_b;
    end else if (paddr == `AOA_OFF_SEL_A) begin
      // The accepted identifier, not the last one written.
      rd[`AOA_ID_W-1:0] = s_q.sel_a;
    end else if (paddr == `AOA_OFF_ZERO_A) begin
      // Zero-volt reference of channel A.
      rd = s_q.zero_a;
    end else if (paddr == `AOA_OFF_SCALE_A) begin
      // Scaling or bit number of channel A.
      rd = s_q.scale_a;
    end else if (paddr == `AOA_OFF_SEL_B) begin
      // The accepted identifier of channel B.
      rd[`AOA_ID_W-1:0] = s_q.sel_b;
    end else if (paddr == `AOA_OFF_ZERO_B) begin
      // Zero-volt reference of channel B.
      rd = s_q.zero_b;
    end else if (paddr == `AOA_OFF_SCALE_B) begin
      // Scaling or bit number of channel B.
      rd = s_q.scale_b;
    end else if (paddr == `AOA_OFF_DIR) begin
      // Pin directions with the output 5 bit on top.
      rd[`AOA_DIO_N:0] = s_q.dir;
    end else if (paddr == `AOA_OFF_DOUT) begin
      // Drive values as written, whatever the direction.
      rd[`AOA_DIO_N-1:0] = s_q.dout;
    end else if (paddr == `AOA_OFF_RELAY) begin
      // Relay states as written.
      rd[`AOA_RELAY_N-1:0] = s_q.relay;
    end else if (paddr == `AOA_OFF_OUT_STAT) begin
      // Driven levels of output pins, then relay states; input pins read zero.
      rd[`AOA_DIO_N-1:0] = s_q.dout & s_q.dir[`AOA_DIO_N-1:0];
      rd[`AOA_DIO_N+:`AOA_RELAY_N] = s_q.relay;
    end else if (paddr == `AOA_OFF_IN_STAT) begin
      // Sampled levels of input pins; output pins read zero here.
      rd[`AOA_DIO_N-1:0] = s_q.din_s2 & ~s_q.dir[`AOA_DIO_N-1:0];
    end else if (paddr == `AOA_OFF_AOUT12) begin
      // Outputs 2 and 1, high half and low half.
      rd = {s_q.aout[1], s_q.aout[0]};
    end else if (paddr == `AOA_OFF_AOUT34) begin
      // Outputs 4 and 3, high half and low half.
      rd = {s_q.aout[3], s_q.aout[2]};
    end else if (paddr == `AOA_OFF_AOUT56) begin
      // Outputs 6 and 5 as driven, not as written.
      rd = {s_q.aout[5], s_q.aout[4]};
    end else if (paddr == `AOA_OFF_STATUS) begin
      // Sticky refusal flag.
      rd[`AOA_STAT_REJECT] = s_q.reject;
    end else if (paddr >= `AOA_OFF_LIST && lbase < 8'(LIST_N * 4) && paddr[1:0] == 2'b00) begin
      // One identifier per aligned word of the list window.
      rd[`AOA_ID_W-1:0] = s_q.list[lbase[7:2]];
    end else begin
      // Unmapped: the answer carries an error.
      hit = 1'b0;
    end

    // Answer: ready, data and error held for exactly one cycle.
    s_d.pready = acc;
    if (acc) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd;
      s_d.pslverr = !hit;
    end else begin
      s_d.prdata = 32'h0000_0000;
      s_d.pslverr = 1'b0;
    end

    // Writes take effect on the edge where ready is sampled high.
    if (done && pwrite && hit) begin
      if (paddr == `AOA_OFF_CTRL) begin
        // Both modes may be on at once; each pair has its own channel.
        s_d.mode_a = wv[`AOA_CTRL_MODE_A];
        s_d.mode_b = wv[`AOA_CTRL_MODE_B];
      end else if (paddr == `AOA_OFF_SEL_A) begin
        // An identifier missing from the list is refused and flagged.
        if (aoa_listed(s_q.list, wv[`AOA_ID_W-1:0])) begin
          s_d.sel_a = wv[`AOA_ID_W-1:0];
        end else begin
          s_d.reject = 1'b1;
        end
      end else if (paddr == `AOA_OFF_ZERO_A) begin
        // Takes effect on the next output update.
        s_d.zero_a = wv;
      end else if (paddr == `AOA_OFF_SCALE_A) begin
        // Zero scaling is legal; a non-binary output is then the difference times 1000, clamped, a binary one shows bit 0.
        s_d.scale_a = wv;
      end else if (paddr == `AOA_OFF_SEL_B) begin
        // Same refusal rule as channel A.
        if (aoa_listed(s_q.list, wv[`AOA_ID_W-1:0])) begin
          s_d.sel_b = wv[`AOA_ID_W-1:0];
        end else begin
          s_d.reject = 1'b1;
        end
      end else if (paddr == `AOA_OFF_ZERO_B) begin
        // Takes effect on the next output update.
        s_d.zero_b = wv;
      end else if (paddr == `AOA_OFF_SCALE_B) begin
        // Zero scaling is legal; a non-binary output is then the difference times 1000, clamped, a binary one shows bit 0.
        s_d.scale_b = wv;
      end else if (paddr == `AOA_OFF_DIR) begin
        // The top bit exists only where output 5 is fitted.
        s_d.dir[`AOA_DIO_N-1:0] = wv[`AOA_DIO_N-1:0];
        s_d.dir[`AOA_DIO_N] = HAS_56 ? wv[`AOA_DIO_N] : 1'b0;
      end else if (paddr == `AOA_OFF_DOUT) begin
        // Reaches the pin only where the direction is output.
        s_d.dout = wv[`AOA_DIO_N-1:0];
      end else if (paddr == `AOA_OFF_RELAY) begin
        // Relays follow the register with no delay of their own.
        s_d.relay = wv[`AOA_RELAY_N-1:0];
      end else if (paddr == `AOA_OFF_AOUT56) begin
        if (HAS_56) begin
          s_d.sw5 = wv[15:0];
          s_d.sw6 = wv[31:16];
        end
      end else if (paddr == `AOA_OFF_STATUS) begin
        // Write one to clear; a refusal in the same cycle is handled above and
        // lands after this point only if it is a selection write, so it cannot
        // be lost: selection writes and status writes are distinct accesses.
        if (wv[`AOA_STAT_REJECT]) begin
          s_d.reject = 1'b0;
        end
      end else if (paddr >= `AOA_OFF_LIST) begin
        // Editing the list leaves present selections in place.
        s_d.list[lbase[7:2]] = wv[`AOA_ID_W-1:0];
      end
    end

    // Channel outputs follow their source only while their mode is selected.
    if (s_q.mode_a) begin
      s_d.aout[0] = aoa_conv(param_val_a, s_q.zero_a, s_q.scale_a, param_bin_a);
      // Output 3 copies output 1, so the pair never disagrees.
      s_d.aout[2] = s_d.aout[0];
    end else begin
      s_d.aout[0] = `AOA_MV_RESET;
      s_d.aout[2] = `AOA_MV_RESET;
    end
    if (s_q.mode_b) begin
      s_d.aout[1] = aoa_conv(param_val_b, s_q.zero_b, s_q.scale_b, param_bin_b);
      // Output 4 copies output 2 in the same way.
      s_d.aout[3] = s_d.aout[1];
    end else begin
      s_d.aout[1] = `AOA_MV_RESET;
      s_d.aout[3] = `AOA_MV_RESET;
    end

    // Output 5 drives only when its direction bit selects output.
    if (HAS_56 && s_q.dir[`AOA_DIO_N] == `AOA_DIR_OUTPUT) begin
      s_d.aout[4] = aoa_clamp(48'(s_q.sw5));
    end else begin
      s_d.aout[4] = `AOA_MV_RESET;
    end
    s_d.aout[5] = HAS_56 ? aoa_clamp(48'(s_q.sw6)) : `AOA_MV_RESET;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  // Every field resets to a constant; voltages start at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.

  // Bus answer.
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  // Accepted identifiers go out to the parameter store.
  assign param_id_a = s_q.sel_a;
  assign param_id_b = s_q.sel_b;
  // Voltages, already saturated.
  assign aout1_mv = s_q.aout[0];
  assign aout2_mv = s_q.aout[1];
  assign aout3_mv = s_q.aout[2];
  assign aout4_mv = s_q.aout[3];
  assign aout5_mv = s_q.aout[4];
  assign aout6_mv = s_q.aout[5];
  // Pin and relay drives.
  assign dio_o = s_q.dout;
  // Enable is low while a pin is set as output.
  assign dio_oe_n = ~s_q.dir[`AOA_DIO_N-1:0];
  assign relay_o = s_q.relay;

endmodule // aoa_top

// File: core/aoa_defines.svh
`ifndef AOA_DEFINES_SVH
`define AOA_DEFINES_SVH

// Register byte offsets on the APB port.
`define AOA_OFF_CTRL 8'h00
`define AOA_OFF_SEL_A 8'h04
`define AOA_OFF_ZERO_A 8'h08
`define AOA_OFF_SCALE_A 8'h0c
`define AOA_OFF_SEL_B 8'h10
`define AOA_OFF_ZERO_B 8'h14
`define AOA_OFF_SCALE_B 8'h18
`define AOA_OFF_DIR 8'h1c
`define AOA_OFF_DOUT 8'h20
`define AOA_OFF_RELAY 8'h24
`define AOA_OFF_OUT_STAT 8'h28
`define AOA_OFF_IN_STAT 8'h2c
`define AOA_OFF_AOUT12 8'h30
`define AOA_OFF_AOUT34 8'h34
`define AOA_OFF_AOUT56 8'h38
`define AOA_OFF_STATUS 8'h3c
`define AOA_OFF_LIST 8'h40

// Field positions.
`define AOA_CTRL_MODE_A 0
`define AOA_CTRL_MODE_B 1
`define AOA_STAT_REJECT 0

// Sizes of the pin groups and the list of assignable identifiers.
`define AOA_DIO_N 8
`define AOA_RELAY_N 2
`define AOA_LIST_N 8
`define AOA_ID_W 16

// Output voltage in millivolts: limits, reset value and the one-volt bit level.
`define AOA_MV_MAX 16'sd10000
`define AOA_MV_MIN -16'sd10000
`define AOA_MV_RESET 16'sd0
`define AOA_MV_BIT_SET 16'sd1000
`define AOA_MV_PER_V 48'sd1000

// Pin direction encoding.
`define AOA_DIR_INPUT 1'b0
`define AOA_DIR_OUTPUT 1'b1

`endif

// File: core/aoa_pkg.sv
`include "aoa_defines.svh"

package aoa_pkg;

  // Complete state of the output assignment block.
  typedef struct packed {
    logic mode_a;                                  // Outputs 1 and 3 follow channel A.
    logic mode_b;                                  // Outputs 2 and 4 follow channel B.
    logic [`AOA_ID_W-1:0] sel_a;                   // Source identifier, channel A.
    logic [`AOA_ID_W-1:0] sel_b;                   // Source identifier, channel B.
    logic signed [31:0] zero_a;                    // Zero-volt reference, channel A.
    logic signed [31:0] zero_b;                    // Zero-volt reference, channel B.
    logic signed [31:0] scale_a;                   // Units per volt or bit number, A.
    logic signed [31:0] scale_b;                   // Units per volt or bit number, B.
    logic [`AOA_DIO_N:0] dir;                      // Pin directions, top bit for output 5.
    logic [`AOA_DIO_N-1:0] dout;                   // Values driven on output pins.
    logic [`AOA_RELAY_N-1:0] relay;                // Relay contact states.
    logic [`AOA_DIO_N-1:0] din_s1;                 // Pin synchroniser, first stage.
    logic [`AOA_DIO_N-1:0] din_s2;                 // Pin synchroniser, second stage.
    logic [`AOA_LIST_N-1:0][`AOA_ID_W-1:0] list;   // Assignable identifiers.
    logic reject;                                  // Sticky: a selection was refused.
    logic signed [15:0] sw5;                       // Software value for output 5.
    logic signed [15:0] sw6;                       // Software value for output 6.
    logic signed [5:0][15:0] aout;                 // Driven voltages of outputs 1 to 6.
    logic pready;                                  // APB ready.
    logic pslverr;                                 // APB error.
    logic [31:0] prdata;                           // APB read data.
  } aoa_state_t;

endpackage : aoa_pkg

// File: tb/aoa_props.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Watches the APB port and the analog outputs of the assignment block.
module aoa_props #(
  parameter int AXES = 2, // Axes served by the unit.
  parameter int CARDS = 2 // Analog option cards fitted.
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire logic [15:0] param_id_a, // Accepted source of channel A.
  input wire logic param_bin_a, // Channel A source is binary.
  input wire logic signed [15:0] aout1_mv, // Output 1.
  input wire logic signed [15:0] aout2_mv, // Output 2.
  input wire logic signed [15:0] aout3_mv, // Output 3.
  input wire logic signed [15:0] aout4_mv, // Output 4.
  input wire logic signed [15:0] aout5_mv, // Output 5.
  input wire logic signed [15:0] aout6_mv // Output 6.
);
  // One clock domain, so one default clocking and one disable.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // The answer comes one cycle after the access edge and stands one cycle.
  ready_one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after the access edge");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("ready without an access");
  data_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside the answer");
  // The map ends below 60h, so anything above must be refused.
  err_map_a: assert property (pready |-> pslverr == (paddr >= 8'h60))
    else $error("error flag does not match the address map");
  out_range_a: assert property (aout1_mv >= -16'sd10000 && aout1_mv <= 16'sd10000)
    else $error("output 1 voltage outside ten volts");
  out2_range_a: assert property (aout2_mv >= -16'sd10000 && aout2_mv <= 16'sd10000)
    else $error("output 2 voltage outside ten volts");
  pair_a_out_a: assert property (aout1_mv == aout3_mv)
    else $error("outputs 1 and 3 differ");
  pair_b_out_a: assert property (aout2_mv == aout4_mv)
    else $error("outputs 2 and 4 differ");
  bin_level_a: assert property (param_bin_a |=> aout1_mv inside {16'sd0, 16'sd1000})
    else $error("binary source gave a level other than 0 or 1 volt");
  // A source change must follow a write to the channel A selection.
  id_write_a: assert property ($changed(param_id_a) |-> $past(pready && pwrite && paddr == 8'h04))
    else $error("source of channel A changed without a selection write");
  card_gate_a: assert property (aout5_mv != 16'sd0 |-> AXES == 2 && CARDS == 2)
    else $error("output 5 driven on a unit without it");
  cover property (pready && pslverr);
  cover property (aout1_mv == -16'sd10000);
  cover property (aout2_mv == 16'sd1000);
endmodule // aoa_props

bind aoa_top aoa_props #(.AXES(AXES), .CARDS(CARDS)) i_aoa_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .param_id_a, .param_bin_a,
  .aout1_mv, .aout2_mv, .aout3_mv, .aout4_mv, .aout5_mv, .aout6_mv);

// File: tb/aoa_src_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Parameter store behind the two channels: answers at once for any identifier.
module aoa_src_model (
  input wire logic [15:0] id_a, // Identifier asked by channel A.
  input wire logic [15:0] id_b, // Identifier asked by channel B.
  output logic signed [31:0] val_a, // Value for channel A.
  output logic bin_a, // Binary flag for channel A.
  output logic signed [31:0] val_b, // Value for channel B.
  output logic bin_b // Binary flag for channel B.
);
  // Each parameter holds a hundred times its identifier, so the bench can predict it.
  // The top identifier bit marks a binary-display parameter.
  assign val_a = $signed({16'h0, id_a}) * 32'sd100;
  assign bin_a = id_a[15];
  assign val_b = $signed({16'h0, id_b}) * 32'sd100;
  assign bin_b = id_b[15];
endmodule // aoa_src_model

// File: tb/aoa_tb.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module aoa_tb;
  logic pclk = 1'b0; // Bus clock, 4 ns period.
  logic presetn = 1'b0; // Reset, held low at start.
  logic psel = 1'b0; // APB select.
  logic penable = 1'b0; // APB enable.
  logic pwrite = 1'b0; // APB direction.
  logic [7:0] paddr = 8'h00; // APB address.
  logic [31:0] pwdata = 32'h0; // APB write data.
  logic [7:0] dio_i = 8'h00; // Pin levels from outside.
  logic [31:0] prdata, rd, bv; // Read data, last read, binary source value.
  logic pready, pslverr, e, bin_a, bin_b; // Handshake, last error, source flags.
  logic [15:0] id_a, id_b; // Requested identifiers.
  logic signed [31:0] val_a, val_b; // Source values.
  logic signed [15:0] ao [1:6]; // Output voltages.
  logic [7:0] dio_o, dio_oe_n; // Pin drives.
  logic [1:0] relay_o; // Relay drives.
  int err_count = 0; // Mismatches.
  int check_count = 0; // Comparisons.
  aoa_top i_aoa_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .param_id_a(id_a), .param_id_b(id_b), .param_val_a(val_a),
    .param_bin_a(bin_a), .param_val_b(val_b), .param_bin_b(bin_b), .aout1_mv(ao[1]),
    .aout2_mv(ao[2]), .aout3_mv(ao[3]), .aout4_mv(ao[4]), .aout5_mv(ao[5]),
    .aout6_mv(ao[6]), .dio_i(dio_i), .dio_o(dio_o), .dio_oe_n(dio_oe_n), .relay_o(relay_o));
  aoa_src_model i_aoa_src_model (.id_a(id_a), .id_b(id_b), .val_a(val_a), .bin_a(bin_a),
    .val_b(val_b), .bin_b(bin_b));
  // Free-running clock.
  initial begin
    forever #2 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Compares with case equality so an unknown never passes.
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; the request is held until ready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Read at the edge itself: the design's updates there are not yet visible,
    // so the values seen are the ones this edge samples.
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_count++;
      stop_test();
    end
  endtask
  // Reads one register and compares it.
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask
  // Expected millivolts: difference over scaling, truncated, then clamped.
  function automatic logic [15:0] mv(input longint v, input longint z, input longint s);
    longint q;
    q = (v - z) * 1000 / s;
    if (q > 10000) q = 10000;
    if (q < -10000) q = -10000;
    return q[15:0];
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc("aout12", 8'h30, 32'h0);
    rdc("aout34", 8'h34, 32'h0);
    chk("oe_n", {24'h0, dio_oe_n}, 32'hff);
    $display("test reset done");
    // Low four pins as outputs, all drive values set, both relays closed.
    dio_i <= 8'haa;
    apb(1'b1, 8'h1c, 32'h0f);
    apb(1'b1, 8'h20, 32'hff);
    apb(1'b1, 8'h24, 32'h3);
    rdc("out_stat", 8'h28, {22'h0, 2'b11, 8'hff & 8'h0f});
    rdc("in_stat", 8'h2c, {24'h0, 8'haa & ~8'h0f});
    chk("oe_n", {24'h0, dio_oe_n}, {24'h0, ~8'h0f});
    chk("drives", {22'h0, relay_o, dio_o}, 32'h3ff);
    $display("test pins done");
    // Only listed identifiers may be selected.
    apb(1'b1, 8'h40, 32'h0010);
    apb(1'b1, 8'h44, 32'h8020);
    apb(1'b1, 8'h04, 32'h0010);
    apb(1'b1, 8'h10, 32'h0099);
    chk("id_a", {16'h0, id_a}, 32'h10);
    chk("id_b", {16'h0, id_b}, 32'h0);
    rdc("reject", 8'h3c, 32'h1);
    apb(1'b1, 8'h3c, 32'h1);
    rdc("reject_clr", 8'h3c, 32'h0);
    $display("test list done");
    // Channel A scaled, then driven into the negative rail.
    apb(1'b1, 8'h08, 32'd600);
    apb(1'b1, 8'h0c, 32'd200);
    apb(1'b1, 8'h00, 32'h1);
    rdc("aout12", 8'h30, {16'h0, mv(1600, 600, 200)});
    rdc("aout34", 8'h34, {16'h0, mv(1600, 600, 200)});
    chk("aout3_pin", {16'h0, ao[3]}, {16'h0, mv(1600, 600, 200)});
    apb(1'b1, 8'h08, 32'd100000);
    rdc("clamp", 8'h30, {16'h0, mv(1600, 100000, 200)});
    chk("aout1_pin", {16'h0, ao[1]}, {16'h0, mv(1600, 100000, 200)});
    $display("test scaled done");
    // Binary source on B with a large zero reference; A switched off.
    bv = 32'h8020 * 32'd100;
    apb(1'b1, 8'h10, 32'h8020);
    apb(1'b1, 8'h14, 32'h12345);
    apb(1'b1, 8'h18, 32'd7);
    apb(1'b1, 8'h00, 32'h2);
    rdc("bin_b7", 8'h34, {bv[7] ? 16'd1000 : 16'd0, 16'h0});
    chk("aout4_pin", {16'h0, ao[4]}, {16'h0, bv[7] ? 16'd1000 : 16'd0});
    apb(1'b1, 8'h18, 32'd8);
    apb(1'b1, 8'h04, 32'h8020);
    apb(1'b1, 8'h0c, 32'd7);
    apb(1'b1, 8'h00, 32'h3);
    rdc("bin_ab", 8'h30, {bv[8] ? 16'd1000 : 16'd0, bv[7] ? 16'd1000 : 16'd0});
    chk("aout2_pin", {16'h0, ao[2]}, {16'h0, bv[8] ? 16'd1000 : 16'd0});
    $display("test binary done");
    // Outputs 5 and 6; only output 5 is gated by the top direction bit.
    apb(1'b1, 8'h1c, 32'h10f);
    apb(1'b1, 8'h38, {16'd3000, 16'd2000});
    rdc("aout56", 8'h38, {16'd3000, 16'd2000});
    chk("aout6_pin", {16'h0, ao[6]}, 32'd3000);
    apb(1'b1, 8'h1c, 32'h0f);
    rdc("aout5_off", 8'h38, {16'd3000, 16'h0});
    chk("aout5_pin", {16'h0, ao[5]}, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    $display("test outputs done");
    stop_test();
  end
endmodule // aoa_tb
